// ### core/fiph_qual.sv
// Input synchroniser and minimum pulse qualifier for one channel
`timescale 1ns/1ns
module fiph_qual
    import fiph_pkg::*;
(
    input  wire logic  i_sys_clk,
    input  wire logic  i_nrst,
    input  wire logic  i_clk_en,
    fiph_qual_if.filt  q
);
    logic             sync1_reg;
    logic             sync2_reg;
    logic             level_reg;
    logic             rise_reg;
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            sync1_reg <= q.raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Level changes only after a stable difference of the minimum pulse time
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_reg   <= '0;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
        end
        else if (i_clk_en)
        begin
            rise_reg <= 1'b0;
            if (sync2_reg == level_reg)
                cnt_reg <= '0;
            else if (cnt_reg == CNT_W'(QUAL_CYC - 1))
            begin
                cnt_reg   <= '0;
                level_reg <= sync2_reg;
                rise_reg  <= sync2_reg;
            end
            else
                cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    assign q.level = level_reg;
    assign q.rise  = rise_reg;

    property p_qual_min;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(level_reg) |-> cnt_reg == '0 && $past(cnt_reg) == CNT_W'(QUAL_CYC - 1);
    endproperty
    a_qual_min: assert property (p_qual_min) else $error("Level rose without full qualify time"); // RULE7
endmodule

// ### core/fiph_top.sv
// Four channel fast input conditioner with pulse capture and interrupt hold
`timescale 1ns/1ns
module fiph_top
    import fiph_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_CYC_DEF
)
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_nrst,
    input  wire logic            i_clk_en,
    input  wire logic [NCH-1:0]  i_field_in,
    input  wire logic            i_function_select_switch,
    input  wire logic            i_display_sel,
    input  wire logic            i_refresh_read,
    input  wire logic [NCH-1:0]  i_int_enable,
    input  wire logic [NPTS-1:0] i_point_state,
    output logic      [NCH-1:0]  o_capture_data,
    output logic      [NCH-1:0]  o_int_req,
    output logic      [NCH-1:0]  o_chan_led,
    output logic      [HALF-1:0] o_led_bank,
    output logic                 o_mode_int
);
    logic             mode1_reg;
    logic             mode_reg;
    logic             disp1_reg;
    logic             disp_reg;
    logic [NCH-1:0]   lvl;
    logic [NCH-1:0]   rise;
    logic [NCH-1:0]   cap_reg;
    logic [NCH-1:0]   held;
    logic [NCH-1:0]   chan_state;
    logic [NPTS-1:0]  points;
    fiph_hold_t       hs_reg  [NCH];
    logic [CNT_W-1:0] cnt_reg [NCH];
    logic [CNT_W-1:0] age_reg [NCH];

    fiph_qual_if qif [NCH] ();

    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        assign qif[g].raw = i_field_in[g];
        assign lvl[g]     = qif[g].level;
        assign rise[g]    = qif[g].rise;
        assign held[g]    = (hs_reg[g] == HS_HOLD);
        fiph_qual u_qual
        (
            .i_sys_clk (i_sys_clk),
            .i_nrst    (i_nrst),
            .i_clk_en  (i_clk_en),
            .q         (qif[g])
        );
    end

    // Switch and selector pins are synchronised
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mode1_reg <= 1'b0;
            mode_reg  <= 1'b0;
            disp1_reg <= 1'b0;
            disp_reg  <= 1'b0;
        end
        else if (i_clk_en)
        begin
            mode1_reg <= i_function_select_switch;
            mode_reg  <= mode1_reg;
            disp1_reg <= i_display_sel;
            disp_reg  <= disp1_reg;
        end
    end

    // Capture latch, set wins over read clear
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cap_reg        <= '0;
            o_capture_data <= '0;
        end
        else if (i_clk_en)
        begin
            if (mode_reg == MODE_INT)
                cap_reg <= '0; // RULE1
            else
                cap_reg <= (cap_reg & ~{NCH{i_refresh_read}}) | rise; // RULE7 RULE8
            if (i_refresh_read && mode_reg != MODE_INT)
                o_capture_data <= cap_reg | rise; // RULE7
        end
    end

    // Interrupt hold state per channel
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                hs_reg[i]  <= HS_IDLE;
                cnt_reg[i] <= '0;
            end
        end
        else if (i_clk_en)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                unique case (hs_reg[i])
                    HS_IDLE:
                    begin
                        if (rise[i] && mode_reg == MODE_INT)
                        begin
                            hs_reg[i]  <= HS_HOLD; // RULE3
                            cnt_reg[i] <= CNT_W'(HOLD_CYC - 1); // RULE10
                        end
                    end
                    HS_HOLD:
                    begin
                        if (mode_reg != MODE_INT || cnt_reg[i] == '0)
                            hs_reg[i] <= HS_IDLE; // RULE1
                        else
                            cnt_reg[i] <= cnt_reg[i] - CNT_W'(1); // RULE9
                    end
                    default:
                    begin
                        hs_reg[i] <= HS_IDLE;
                    end
                endcase
            end
        end
    end

    // Reported state and LEDs
    assign chan_state = (mode_reg == MODE_INT) ? held : cap_reg;
    assign points     = {i_point_state[NPTS-1:NCH], chan_state};

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_chan_led <= '0;
            o_led_bank <= '0;
            o_int_req  <= '0;
            o_mode_int <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_chan_led <= chan_state; // RULE6
            o_led_bank <= (disp_reg == SEL_UPPER) ? points[NPTS-1:HALF] : points[HALF-1:0]; // RULE5
            o_int_req  <= (mode_reg == MODE_INT) ? (held & i_int_enable) : '0; // RULE2
            o_mode_int <= mode_reg;
        end
    end

    // Helper: cycles spent in hold
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < NCH; i++)
                age_reg[i] <= '0;
        end
        else if (i_clk_en)
        begin
            for (int i = 0; i < NCH; i++)
                age_reg[i] <= held[i] ? age_reg[i] + CNT_W'(1) : '0;
        end
    end

    // Checks
    property p_mode_cap;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_clk_en && mode_reg != MODE_INT) |=> (held == '0 && o_int_req == '0);
    endproperty
    a_mode_cap: assert property (p_mode_cap) else $error("Hold active in capture mode"); // RULE1

    property p_led_bank;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        i_clk_en |=> o_led_bank == ($past(disp_reg) ? $past(points[NPTS-1:HALF]) : $past(points[HALF-1:0]));
    endproperty
    a_led_bank: assert property (p_led_bank) else $error("LED bank shows wrong half"); // RULE5

    property p_chan_led;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        i_clk_en |=> o_chan_led == $past(chan_state);
    endproperty
    a_chan_led: assert property (p_chan_led) else $error("Channel LED disagrees with state"); // RULE6

    for (genvar g = 0; g < NCH; g++)
    begin : g_chk
        sequence s_start;
            i_clk_en && hs_reg[g] == HS_IDLE && rise[g] && mode_reg == MODE_INT;
        endsequence
        sequence s_loaded;
            held[g] && cnt_reg[g] == CNT_W'(HOLD_CYC - 1) && age_reg[g] == '0;
        endsequence

        property p_restart;
            @(posedge i_sys_clk) disable iff (!i_nrst)
            s_start |=> s_loaded;
        endproperty
        a_restart: assert property (p_restart) else $error("Hold did not start on idle edge"); // RULE10

        property p_hold_len;
            @(posedge i_sys_clk) disable iff (!i_nrst)
            ($fell(held[g]) && mode_reg == MODE_INT) |-> $past(age_reg[g]) == CNT_W'(HOLD_CYC - 1);
        endproperty
        a_hold_len: assert property (p_hold_len) else $error("Hold interval length wrong"); // RULE3

        property p_no_retrig;
            @(posedge i_sys_clk) disable iff (!i_nrst)
            (i_clk_en && held[g] && cnt_reg[g] != '0 && mode_reg == MODE_INT)
                |=> held[g] && cnt_reg[g] == $past(cnt_reg[g]) - CNT_W'(1);
        endproperty
        a_no_retrig: assert property (p_no_retrig) else $error("Hold counter retriggered"); // RULE9

        property p_latch;
            @(posedge i_sys_clk) disable iff (!i_nrst)
            (i_clk_en && rise[g] && mode_reg != MODE_INT) ##1 (!i_refresh_read && mode_reg != MODE_INT)
                |-> cap_reg[g];
        endproperty
        a_latch: assert property (p_latch) else $error("Captured pulse lost before read"); // RULE7

        property p_one_scan;
            @(posedge i_sys_clk) disable iff (!i_nrst)
            (i_clk_en && i_refresh_read && !rise[g] && mode_reg != MODE_INT) |=> !cap_reg[g];
        endproperty
        a_one_scan: assert property (p_one_scan) else $error("Long input reported past one scan"); // RULE8
    end
endmodule

// ### dv/fiph_field_model.sv
// Field input source and per point interrupt enables
`timescale 1ns/1ns
module fiph_field_model
(
    input  wire logic       i_sys_clk,
    output logic      [3:0] o_field,
    output logic      [3:0] o_int_enable
);
    initial
    begin
        o_field      = 4'h0;
        o_int_enable = 4'h0;
    end

    // Set one input level at a clock edge
    task automatic set_in(input int ch, input logic v);
        @(posedge i_sys_clk);
        o_field[ch] <= v;
    endtask

    // Pulse held for the given width
    task automatic pulse(input int ch, input int ncyc);
        set_in(ch, 1'b1);
        repeat (ncyc) @(posedge i_sys_clk);
        o_field[ch] <= 1'b0;
    endtask

    // Per point interrupt enables
    task automatic enable(input logic [3:0] en);
        @(posedge i_sys_clk);
        o_int_enable <= en;
    endtask
endmodule

// ### dv/fiph_top_tb.sv
// Self-checking bench for the fast input conditioner
`timescale 1ns/1ns
module fiph_top_tb;
    import fiph_pkg::*;
    localparam int   HOLD = 2500;
    logic            clk;
    logic            nrst;
    logic            ce;
    logic            sw;
    logic            dsel;
    logic            rd;
    logic [NCH-1:0]  field;
    logic [NCH-1:0]  en;
    logic [NCH-1:0]  cap;
    logic [NCH-1:0]  irq;
    logic [NCH-1:0]  led;
    logic [NPTS-1:0] pts;
    logic [HALF-1:0] bank;
    logic            mode;
    int              n_mismatch;
    int              total_checks;
    int              cyc;
    int              irq_cnt;

    fiph_top #(.HOLD_CYC(HOLD)) dut (.i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(ce), .i_field_in(field),
        .i_function_select_switch(sw), .i_display_sel(dsel), .i_refresh_read(rd), .i_int_enable(en),
        .i_point_state(pts), .o_capture_data(cap), .o_int_req(irq), .o_chan_led(led),
        .o_led_bank(bank), .o_mode_int(mode));
    fiph_field_model src (.i_sys_clk(clk), .o_field(field), .o_int_enable(en));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Cycle count, hold length count, hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (irq[0] === 1'b1)
            irq_cnt <= irq_cnt + 1;
        if (cyc == 30000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // One refresh read, then compare the capture word
    task automatic rd_cap(input logic [3:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("capture", {28'h0, exp}, {28'h0, cap});
    endtask

    initial
    begin
        cyc          = 0;
        irq_cnt      = 0;
        n_mismatch   = 0;
        total_checks = 0;
        nrst         = 1'b0;
        ce           = 1'b1;
        sw           = 1'b0;
        dsel         = 1'b0;
        rd           = 1'b0;
        pts          = 64'h0123_4567_89ab_cdef;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        wt(2);
        // Capture mode: pulse latched until read
        src.pulse(0, 1100);
        wt(1100);
        chk("led", 32'h1, {28'h0, led});
        rd_cap(4'h1);
        rd_cap(4'h0);
        // Long input reported for one read only
        src.set_in(1, 1'b1);
        wt(1010);
        chk("bank_low", 32'h89ab_cde2, bank);
        rd_cap(4'h2);
        rd_cap(4'h0);
        src.set_in(1, 1'b0);
        // Too short a pulse is dropped
        src.pulse(2, 500);
        wt(1200);
        rd_cap(4'h0);
        @(posedge clk);
        dsel <= 1'b1;
        wt(4);
        chk("bank_high", 32'h0123_4567, bank);
        // Clock enable low freezes the selector path
        @(posedge clk);
        ce   <= 1'b0;
        dsel <= 1'b0;
        wt(4);
        chk("bank_frozen", 32'h0123_4567, bank);
        @(posedge clk);
        ce <= 1'b1;
        wt(4);
        chk("bank_resume", 32'h89ab_cde0, bank);
        // Interrupt mode: one hold despite a second pulse
        src.enable(4'b0001);
        @(posedge clk);
        sw <= 1'b1;
        wt(4);
        chk("mode", 32'h1, {31'h0, mode});
        irq_cnt = 0;
        src.pulse(0, 1100);
        wt(1100);
        src.pulse(0, 1100);
        wt(3000);
        chk("hold_len", HOLD, irq_cnt);
        // Disabled point shows on LED without request
        src.set_in(1, 1'b1);
        wt(1010);
        chk("led_int", 32'h2, {28'h0, led});
        chk("irq_off", 32'h0, {28'h0, irq});
        // Back to capture: nothing kept from interrupt mode
        @(posedge clk);
        sw <= 1'b0;
        wt(4);
        rd_cap(4'h0);
        end_sim();
    end
endmodule

// ### pkg/fiph_pkg.sv
// Constants and types for the fast input pulse hold block
// How it works
// (RULE1) The function select switch picks pulse capture or interrupt mode for all four channels.
// (RULE2) The controller enables or disables interrupt generation separately on each of the four points.
// (RULE3) In interrupt mode a rising input is reported on for 512 us whatever the input does after it.
// (RULE4) The field source holds each pulse high for at least 50 us, or it may go unseen.
// (RULE5) Display selector position 1 shows points 1 to 32 on the LEDs, position 2 shows points 33 to 64.
// (RULE6) Each channel LED is lit exactly while that channel is reported on.
// (RULE7) In capture mode a pulse of 50 us or more is latched until the next CPU read.
// (RULE8) In capture mode an input that stays on is reported on for only one scan; a rise in the same cycle as a refresh read is reported on two reads.
// (RULE9) During the interrupt hold time further pulses on that channel are ignored.
// (RULE10) The hold time is counted per channel and restarts only on a rising edge seen while idle.
package fiph_pkg;
    localparam int    NCH           = 4;
    localparam int    NPTS          = 64;
    localparam int    HALF          = 32;
    localparam int    CNT_W         = 14;
    localparam longint CLK_HZ       = 20_000_000;
    localparam longint QUAL_TIME_US = 50;
    localparam longint HOLD_TIME_US = 512;
    localparam longint US_PER_S     = 1_000_000;
    // Least time rounds up, hold time rounds down
    localparam int    QUAL_CYC      = int'((QUAL_TIME_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
    localparam int    HOLD_CYC_DEF  = int'((HOLD_TIME_US * CLK_HZ) / US_PER_S);
    localparam logic  MODE_INT      = 1'b1;
    localparam logic  SEL_UPPER     = 1'b1;

    typedef enum logic [1:0]
    {
        HS_IDLE = 2'b01,
        HS_HOLD = 2'b10
    } fiph_hold_t;
endpackage

// ### pkg/fiph_qual_if.sv
// Carrier between the top and one input qualifier
`timescale 1ns/1ns
interface fiph_qual_if;
    logic raw;
    logic level;
    logic rise;
    modport filt (input raw, output level, output rise);
    modport user (output raw, input level, input rise);
endinterface
